//--- rtl/scc_pkg.sv
// Purpose: Constants for the sensor channel configuration register.
// Assumes: 10 MHz device clock, 16-bit register word.
// Notes:   Field positions, codes and timing counts live here, except the channel sequence table in scc_config_reg.
package scc_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam logic [3:0]  REG_OFFSET = 4'h1;
  localparam logic [15:0] REG_RESET  = 16'h0000;

  localparam int unsigned ANGLE_LSB = 14;
  localparam int unsigned SLEEP_LSB = 10;
  localparam int unsigned CHSEL_LSB = 6;
  localparam int unsigned ZRNG_LSB  = 4;
  localparam int unsigned YRNG_LSB  = 2;
  localparam int unsigned XRNG_LSB  = 0;

  localparam logic [2:0] MODE_DUTY_CYCLE = 3'h4;
  localparam logic [2:0] MODE_INTERVAL   = 3'h2;

  localparam logic [1:0] ANGLE_OFF = 2'h0;
  localparam logic [1:0] ANGLE_XY  = 2'h1;
  localparam logic [1:0] ANGLE_YZ  = 2'h2;
  localparam logic [1:0] ANGLE_XZ  = 2'h3;

  localparam logic [1:0] RANGE_MID  = 2'h0;
  localparam logic [1:0] RANGE_LOW  = 2'h1;
  localparam logic [1:0] RANGE_HIGH = 2'h2;
  localparam logic [1:0] RANGE_BAD  = 2'h3;

  localparam logic [3:0] SLEEP_LAST = 4'h9;

  // Axis codes used in sample sequences.
  localparam logic [1:0] AX_X = 2'h0;
  localparam logic [1:0] AX_Y = 2'h1;
  localparam logic [1:0] AX_Z = 2'h2;

  localparam int unsigned SEQ_MAX = 6;

  // Sleep interval in milliseconds per code, then converted to cycles.
  function automatic int unsigned sleep_ms(input logic [3:0] code);
    case (code)
      4'h0:    sleep_ms = 1;
      4'h1:    sleep_ms = 5;
      4'h2:    sleep_ms = 10;
      4'h3:    sleep_ms = 15;
      4'h4:    sleep_ms = 20;
      4'h5:    sleep_ms = 30;
      4'h6:    sleep_ms = 50;
      4'h7:    sleep_ms = 100;
      4'h8:    sleep_ms = 500;
      4'h9:    sleep_ms = 1000;
      default: sleep_ms = 1;
    endcase
  endfunction

  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

endpackage

//--- rtl/scc_config_reg.sv
// Purpose: Sensor channel configuration register and its field decoders.
// Assumes: Register port is synchronous to clk_i; conv_start_i pulses
//          once per conversion from the conversion engine.
// Notes:   Decoded fields are captured at conversion start so that a
//          write never disturbs a conversion in progress.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Angle select picks off, XY, YZ or XZ.
// - Sleep codes 0-9 give 1 to 1000 ms.
// - Sleep codes A-F behave as code zero.
// - Sleep interval applies only in interval mode.
// - Channel codes 0-7 are per-axis X,Y,Z mask.
// - Codes 8-D are three-sample axis sequences.
// - Code E five samples, code F six samples.
// - Three two-bit range selectors, Z,Y,X.
// - Range codes 0 mid, 1 low, 2 high.
// - Range code 3 behaves as code zero.
// - Register at offset one, resets to zero.
// - Operating mode four enters duty-cycled mode.
module scc_config_reg #(
  parameter int unsigned SLEEP_MS_SCALE = scc_pkg::CYC_PER_MS
) (
  input  wire  logic        clk_i,
  input  wire  logic        arst_n_i,
  input  wire  logic [3:0]  reg_addr_i,
  input  wire  logic        reg_wr_i,
  input  wire  logic [15:0] reg_wdata_i,
  output logic [15:0]       reg_rdata_o,
  input  wire  logic [2:0]  operating_mode_i,
  input  wire  logic        conv_start_i,
  output logic              duty_cycle_o,
  output logic [1:0]        angle_sel_o,
  output logic              angle_en_o,
  output logic [31:0]       sleep_cycles_o,
  output logic              sleep_apply_o,
  output logic [2:0]        seq_len_o,
  output logic [11:0]       seq_axes_o,
  output logic [1:0]        x_range_o,
  output logic [1:0]        y_range_o,
  output logic [1:0]        z_range_o
);

  typedef struct packed {
    logic [2:0]  len;
    logic [11:0] axes;
  } scc_seq_t;

  // Range code three is unused and behaves as the default middle range.
  function automatic logic [1:0] fix_range(input logic [1:0] code);
    fix_range = (code == scc_pkg::RANGE_BAD) ? scc_pkg::RANGE_MID
                                             : code;
  endfunction

  // Unused sleep codes fall back to code zero rather than saturating.
  function automatic logic [3:0] fix_sleep(input logic [3:0] code);
    fix_sleep = (code > scc_pkg::SLEEP_LAST) ? 4'h0 : code;
  endfunction

  // The product is cut to 32 bits; the longest interval fits easily.
  function automatic logic [31:0] sleep_cycles(input logic [3:0] code);
    sleep_cycles = 32'(scc_pkg::sleep_ms(fix_sleep(code))
                       * SLEEP_MS_SCALE);
  endfunction

  // Packs a sample sequence, first sample in the low two bits.
  // Slots past the length hold the X code, which is zero.
  function automatic scc_seq_t pack_seq(input logic [2:0] len,
                                        input logic [1:0] s0,
                                        input logic [1:0] s1,
                                        input logic [1:0] s2,
                                        input logic [1:0] s3,
                                        input logic [1:0] s4,
                                        input logic [1:0] s5);
    pack_seq.len  = len;
    pack_seq.axes = {s5, s4, s3, s2, s1, s0};
  endfunction

  function automatic scc_seq_t decode_seq(input logic [3:0] code);
    case (code)
      4'h0: decode_seq = pack_seq(3'h0, scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h1: decode_seq = pack_seq(3'h1, scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h2: decode_seq = pack_seq(3'h1, scc_pkg::AX_Y, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h3: decode_seq = pack_seq(3'h2, scc_pkg::AX_X, scc_pkg::AX_Y,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h4: decode_seq = pack_seq(3'h1, scc_pkg::AX_Z, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h5: decode_seq = pack_seq(3'h2, scc_pkg::AX_X, scc_pkg::AX_Z,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h6: decode_seq = pack_seq(3'h2, scc_pkg::AX_Y, scc_pkg::AX_Z,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h7: decode_seq = pack_seq(3'h3, scc_pkg::AX_X, scc_pkg::AX_Y,
                                  scc_pkg::AX_Z, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h8: decode_seq = pack_seq(3'h3, scc_pkg::AX_X, scc_pkg::AX_Y,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'h9: decode_seq = pack_seq(3'h3, scc_pkg::AX_Y, scc_pkg::AX_X,
                                  scc_pkg::AX_Y, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'hA: decode_seq = pack_seq(3'h3, scc_pkg::AX_Y, scc_pkg::AX_Z,
                                  scc_pkg::AX_Y, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'hB: decode_seq = pack_seq(3'h3, scc_pkg::AX_Z, scc_pkg::AX_Y,
                                  scc_pkg::AX_Z, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'hC: decode_seq = pack_seq(3'h3, scc_pkg::AX_Z, scc_pkg::AX_X,
                                  scc_pkg::AX_Z, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'hD: decode_seq = pack_seq(3'h3, scc_pkg::AX_X, scc_pkg::AX_Z,
                                  scc_pkg::AX_X, scc_pkg::AX_X,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      4'hE: decode_seq = pack_seq(3'h5, scc_pkg::AX_X, scc_pkg::AX_Y,
                                  scc_pkg::AX_Z, scc_pkg::AX_Y,
                                  scc_pkg::AX_X, scc_pkg::AX_X);
      default: decode_seq = pack_seq(3'h6, scc_pkg::AX_X, scc_pkg::AX_Y,
                                     scc_pkg::AX_Z, scc_pkg::AX_Z,
                                     scc_pkg::AX_Y, scc_pkg::AX_X);
    endcase
  endfunction

  // Reset values of the captured outputs are the decode of the reset word.
  localparam logic [1:0]  ANGLE_RESET =
    scc_pkg::REG_RESET[scc_pkg::ANGLE_LSB +: 2];
  localparam logic        ANGLE_EN_RESET =
    ANGLE_RESET != scc_pkg::ANGLE_OFF;
  localparam logic [31:0] SLEEP_RESET =
    sleep_cycles(scc_pkg::REG_RESET[scc_pkg::SLEEP_LSB +: 4]);
  localparam scc_seq_t    SEQ_RESET =
    decode_seq(scc_pkg::REG_RESET[scc_pkg::CHSEL_LSB +: 4]);
  localparam logic [1:0]  X_RANGE_RESET =
    fix_range(scc_pkg::REG_RESET[scc_pkg::XRNG_LSB +: 2]);
  localparam logic [1:0]  Y_RANGE_RESET =
    fix_range(scc_pkg::REG_RESET[scc_pkg::YRNG_LSB +: 2]);
  localparam logic [1:0]  Z_RANGE_RESET =
    fix_range(scc_pkg::REG_RESET[scc_pkg::ZRNG_LSB +: 2]);

  logic [15:0] cfg_word;
  logic [15:0] next_cfg_word;
  logic [1:0]  next_angle_sel;
  logic        next_angle_en;
  logic [31:0] next_sleep_cycles;
  scc_seq_t    next_seq;
  logic [1:0]  next_x_range;
  logic [1:0]  next_y_range;
  logic [1:0]  next_z_range;

  always_comb
  begin
    next_cfg_word = cfg_word;
    if (reg_wr_i && reg_addr_i == scc_pkg::REG_OFFSET)
    begin
      next_cfg_word = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_word <= scc_pkg::REG_RESET;
    end
    else
    begin
      cfg_word <= next_cfg_word;
    end
  end

  // Reads are combinational so the host sees the word in the same cycle.
  always_comb
  begin
    reg_rdata_o = 16'h0000;
    if (reg_addr_i == scc_pkg::REG_OFFSET)
    begin
      reg_rdata_o = cfg_word;
    end
  end

  // Mode flags follow the mode input at once: the mode field lives in
  // another register and is not captured at conversion start here.
  always_comb
  begin
    sleep_apply_o = operating_mode_i == scc_pkg::MODE_INTERVAL;
    duty_cycle_o  = operating_mode_i == scc_pkg::MODE_DUTY_CYCLE;
  end

  // Every decoded group captures only at conversion start, so a write
  // between conversions never disturbs the one that is running. A write
  // in the same cycle as the start is already taken.
  always_comb
  begin
    next_angle_sel = angle_sel_o;
    next_angle_en  = angle_en_o;
    if (conv_start_i)
    begin
      next_angle_sel = next_cfg_word[scc_pkg::ANGLE_LSB +: 2];
      next_angle_en  = next_cfg_word[scc_pkg::ANGLE_LSB +: 2]
                       != scc_pkg::ANGLE_OFF;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      angle_sel_o <= ANGLE_RESET;
      angle_en_o  <= ANGLE_EN_RESET;
    end
    else
    begin
      angle_sel_o <= next_angle_sel;
      angle_en_o  <= next_angle_en;
    end
  end

  always_comb
  begin
    next_sleep_cycles = sleep_cycles_o;
    if (conv_start_i)
    begin
      next_sleep_cycles =
        sleep_cycles(next_cfg_word[scc_pkg::SLEEP_LSB +: 4]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sleep_cycles_o <= SLEEP_RESET;
    end
    else
    begin
      sleep_cycles_o <= next_sleep_cycles;
    end
  end

  always_comb
  begin
    next_seq = '{len: seq_len_o, axes: seq_axes_o};
    if (conv_start_i)
    begin
      next_seq = decode_seq(next_cfg_word[scc_pkg::CHSEL_LSB +: 4]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      seq_len_o  <= SEQ_RESET.len;
      seq_axes_o <= SEQ_RESET.axes;
    end
    else
    begin
      seq_len_o  <= next_seq.len;
      seq_axes_o <= next_seq.axes;
    end
  end

  always_comb
  begin
    next_x_range = x_range_o;
    next_y_range = y_range_o;
    next_z_range = z_range_o;
    if (conv_start_i)
    begin
      next_z_range = fix_range(
                       next_cfg_word[scc_pkg::ZRNG_LSB +: 2]);
      next_y_range = fix_range(
                       next_cfg_word[scc_pkg::YRNG_LSB +: 2]);
      next_x_range = fix_range(
                       next_cfg_word[scc_pkg::XRNG_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      x_range_o <= X_RANGE_RESET;
      y_range_o <= Y_RANGE_RESET;
      z_range_o <= Z_RANGE_RESET;
    end
    else
    begin
      x_range_o <= next_x_range;
      y_range_o <= next_y_range;
      z_range_o <= next_z_range;
    end
  end

endmodule // scc_config_reg

`default_nettype wire

//--- verif/scc_config_reg_properties.sv
// Purpose: Port checks. Assumes: one clock. Notes: bound below.
`timescale 1ns/1ps
`default_nettype none
module scc_props (
  input wire logic clk_i, arst_n_i, reg_wr_i, conv_start_i, duty_cycle_o,
  input wire logic angle_en_o, sleep_apply_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o,
  input wire logic [2:0] operating_mode_i,
  input wire logic [1:0] angle_sel_o, z_range_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // A write in the capture cycle would hide what was captured.
  sequence snap; conv_start_i && !reg_wr_i && reg_addr_i == 4'h1; endsequence
  rd_zero_a: assert property (
    reg_addr_i != 4'h1 |-> reg_rdata_o == 16'h0) else $error("rd");
  wr_back_a: assert property (
    reg_wr_i && reg_addr_i == 4'h1 ##1 reg_addr_i == 4'h1 |->
    reg_rdata_o == $past(reg_wdata_i)) else $error("wr");
  cfg_hold_a: assert property (
    !conv_start_i |=> $stable({angle_sel_o, z_range_o})) else $error("hold");
  angle_snap_a: assert property (
    snap |=> angle_sel_o == $past(reg_rdata_o[15:14])) else $error("ang");
  z_fold_a: assert property (
    snap |=> z_range_o == ($past(reg_rdata_o[5:4]) == 2'h3 ? 2'h0 :
    $past(reg_rdata_o[5:4]))) else $error("z");
  angle_flag_a: assert property (
    angle_en_o == (angle_sel_o != 2'h0)) else $error("en");
  duty_mode_a: assert property (
    duty_cycle_o == (operating_mode_i == 3'h4)) else $error("duty");
  sleep_gate_a: assert property (
    sleep_apply_o == (operating_mode_i == 3'h2)) else $error("apply");
  snap_c: cover property (snap);
  wr_conv_c: cover property (reg_wr_i && conv_start_i);
  duty_c: cover property (duty_cycle_o);
endmodule // scc_props
bind scc_config_reg scc_props u_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
  .conv_start_i(conv_start_i), .duty_cycle_o(duty_cycle_o),
  .angle_en_o(angle_en_o), .sleep_apply_o(sleep_apply_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .operating_mode_i(operating_mode_i),
  .angle_sel_o(angle_sel_o), .z_range_o(z_range_o));
`default_nettype wire

//--- verif/scc_host.sv
// Purpose: Host model. Assumes: drives 1 ns after the edge. Notes: none.
`timescale 1ns/1ps
`default_nettype none
module scc_host (
  input  wire logic        clk_i,
  output var  logic [3:0]  addr_o,
  output var  logic        wr_o,
  output var  logic        conv_o,
  output var  logic [15:0] wdata_o
);
  initial {addr_o, wdata_o, wr_o, conv_o} = {4'h1, 18'h0};
  task automatic put(logic [3:0] a, logic [15:0] d, logic w, logic c);
    @(posedge clk_i);
    #1 {addr_o, wdata_o, wr_o, conv_o} = {a, d, w, c};
    @(posedge clk_i);
    #1 {wr_o, conv_o, wdata_o} = {2'h0, ~d};
  endtask
endmodule // scc_host
`default_nettype wire

//--- verif/tb_sensor_channel_config_register.sv
// Purpose: Bench. Assumes: 10 clocks per ms. Notes: rows sweep all codes.
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_channel_config_register;
  localparam int MS [10] = '{1, 5, 10, 15, 20, 30, 50, 100, 500, 1000};
  localparam logic [11:0] AX [16] = '{12'h000, 12'h000, 12'h001, 12'h004,
    12'h002, 12'h008, 12'h009, 12'h024,
    12'h004, 12'h011, 12'h019, 12'h026,
    12'h022, 12'h008, 12'h064, 12'h1A4};
  logic clk_i = 0, arst_n_i = 0, reg_wr_i, conv_start_i, duty_cycle_o;
  logic angle_en_o, sleep_apply_o;
  logic [2:0] operating_mode_i = 0, seq_len_o;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, w;
  logic [1:0] angle_sel_o, x_range_o, y_range_o, z_range_o, a;
  logic [31:0] sleep_cycles_o;
  logic [11:0] seq_axes_o, m;
  int fails = 0, samples_checked = 0, e;
  always #50 clk_i = ~clk_i;
  scc_host host (.clk_i(clk_i), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
    .conv_o(conv_start_i), .wdata_o(reg_wdata_i));
  scc_config_reg #(.SLEEP_MS_SCALE(10)) dut (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .operating_mode_i(operating_mode_i), .conv_start_i(conv_start_i),
    .duty_cycle_o(duty_cycle_o), .angle_sel_o(angle_sel_o),
    .angle_en_o(angle_en_o), .sleep_cycles_o(sleep_cycles_o),
    .sleep_apply_o(sleep_apply_o), .seq_len_o(seq_len_o),
    .seq_axes_o(seq_axes_o), .x_range_o(x_range_o),
    .y_range_o(y_range_o), .z_range_o(z_range_o));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #300000 fails++;
    tally_and_finish();
  end
  initial
  begin
    #499 chk("rst", {reg_rdata_o, angle_sel_o, seq_len_o}, 0);
    #2 arst_n_i = 1;
    for (int i = 0; i < 16; i++)
    begin
      a = i[1:0];
      w = {a, i[3:0], i[3:0], a, a, a};
      e = i < 8 ? $countones(i[2:0]) : i < 14 ? 3 : i - 9;
      m = 12'hFFF >> 12 - 2 * e;
      host.put(4'h1, w, 1, 0);
      chk("rd", reg_rdata_o, w);
      chk("hold", angle_sel_o, 2'(i - (i > 0)));
      host.put(4'h1, w, 0, 1);
      chk("ang", {angle_en_o, angle_sel_o}, {a != 0, a});
      chk("x", x_range_o, a == 3 ? 2'h0 : a);
      chk("y", y_range_o, a == 3 ? 2'h0 : a);
      chk("z", z_range_o, a == 3 ? 2'h0 : a);
      chk("slp", sleep_cycles_o, 10 * (i < 10 ? MS[i] : 1));
      chk("len", seq_len_o, e);
      chk("ax", seq_axes_o & m, AX[i]);
      $display("row %0d done", i);
    end
    host.put(4'h2, 16'h1234, 1, 0);
    chk("off", reg_rdata_o, 0);
    host.put(4'h1, 16'h0, 0, 0);
    chk("kept", reg_rdata_o, 16'hFFFF);
    host.put(4'h1, 16'h4000, 1, 1);
    chk("same", angle_sel_o, 2'h1);
    $display("write and offset tests done");
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_i);
      #1 operating_mode_i = 3'(k);
      #1 chk("duty", duty_cycle_o, k == scc_pkg::MODE_DUTY_CYCLE);
      chk("apply", sleep_apply_o, k == scc_pkg::MODE_INTERVAL);
    end
    $display("mode tests done");
    arst_n_i = 0;
    #1 chk("rst2", {reg_rdata_o, angle_sel_o, seq_len_o, x_range_o}, 0);
    chk("rstslp", sleep_cycles_o, 10);
    @(posedge clk_i);
    @(posedge clk_i);
    #1 arst_n_i = 1;
    host.put(4'h1, 16'h8000, 1, 1);
    chk("rdrel", reg_rdata_o, 16'h8000);
    chk("angrel", angle_sel_o, 2'h2);
    $display("hand tests done");
    tally_and_finish();
  end
endmodule // tb_sensor_channel_config_register
`default_nettype wire
